//--- shared/pcf_pkg.sv
/*
  Package for the pin control block: register map, field layout,
  reset values, trigger and function-slot codes, bus carriers.
  Assumes a 32-bit AXI4-Lite register bus and one clock domain.
*/
package pcf_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [3:0] PIN_CONTROL_OFS = 4'h0;
  localparam logic [3:0] IRQ_STATUS_OFS  = 4'h4;
  localparam logic [3:0] IRQ_MASK_OFS    = 4'h8;
  localparam logic [3:0] PIN_STATUS_OFS  = 4'hC;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int FLAG_BIT   = 24;
  localparam int TRIG_LSB   = 16;
  localparam int FUNC_LSB   = 8;
  localparam int DRIVE_BIT  = 6;
  localparam int FILTER_BIT = 4;

  // ****************************************
  // Reset values and read-zero constant
  // ****************************************
  localparam logic [3:0]  TRIG_RESET   = 4'h0;
  localparam logic [2:0]  FUNC_RESET   = 3'h0;
  localparam logic        DRIVE_RESET  = 1'b0;
  localparam logic        FILTER_RESET = 1'b0;
  localparam logic        MASK_RESET   = 1'b0;
  localparam logic [31:0] READ_ZERO    = 32'h0000_0000;

  // ****************************************
  // Trigger and function-slot codes
  // ****************************************
  localparam logic [3:0] TRIG_OFF     = 4'h0;
  localparam logic [3:0] TRIG_LOW     = 4'h8;
  localparam logic [3:0] TRIG_RISE    = 4'h9;
  localparam logic [3:0] TRIG_FALL    = 4'hA;
  localparam logic [3:0] TRIG_EITHER  = 4'hB;
  localparam logic [3:0] TRIG_HIGH    = 4'hC;
  localparam logic [2:0] FUNC_ANALOG  = 3'h0;
  localparam logic [2:0] FUNC_GPIO    = 3'h1;

  // ****************************************
  // AXI4-Lite responses
  // ****************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [3:0]  irq_trigger_select;
    logic [2:0]  func_select;
    logic        high_drive_select;
    logic        input_filter_on;
  } pcf_cfg_t;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  resp;
  } pcf_rd_t;

endpackage

//--- rtl/pcf_sync.sv
/*
  Two-flop synchroniser for the pin level.
  Assumes the pin is asynchronous to ref_clk_i.
*/
module pcf_sync (
  input  wire logic ref_clk_i,
  input  wire logic reset_n_i,
  input  wire logic clk_en_i,
  input  wire logic async_i,
  output logic      sync_o
);

  logic meta_r;
  logic sync_r;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else if (clk_en_i) begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule

//--- rtl/pcf_pin_control.sv
/*
  Pin control block for one port pin: control register, function-slot
  routing, drive and filter controls, pin event flag and interrupt.
  Assumes an AXI4-Lite master on ref_clk_i and a pin level that may be
  asynchronous; capability straps are constant during operation.
*/
// Added by the designer: the AXI4-Lite register port and the register offsets.
// Notes on behaviour
// - Code 1011 sets the event flag on either pin edge.
// - Code 1100 sets the event flag while the pin is high.
// - Bits 15..11, 7, 5 and 3 read zero and ignore writes.
// - Function field 10..8 routes the pin: 000 analog, 001 GPIO, others alternatives.
// - Bit 6 picks low (0) or high (1) output drive.
// - Without drive capability the drive bit is read-only.
// - Drive and filter settings apply in every digital function slot.
// - Bit 4 enables the passive input filter when one.
// - Without filter capability the filter bit is read-only.
// - Trigger field 19..16: 0000 off, 1000 low, 1001 rise, 1010 fall.
// - Event flag in bit 24 stays set until a one is written to it.
// - A level trigger still active sets the flag again at once after clear.
module pcf_pin_control #(
  parameter logic HAS_DRIVE  = 1'b1,
  parameter logic HAS_FILTER = 1'b1,
  parameter logic HAS_IRQ    = 1'b1
) (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        clk_en_i,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_awaddr_i,
  input  wire logic        s_awvalid_i,
  output logic             s_awready_o,
  input  wire logic [31:0] s_wdata_i,
  input  wire logic [3:0]  s_wstrb_i,
  input  wire logic        s_wvalid_i,
  output logic             s_wready_o,
  output logic [1:0]       s_bresp_o,
  output logic             s_bvalid_o,
  input  wire logic        s_bready_i,
  input  wire logic [3:0]  s_araddr_i,
  input  wire logic        s_arvalid_i,
  output logic             s_arready_o,
  output logic [31:0]      s_rdata_o,
  output logic [1:0]       s_rresp_o,
  output logic             s_rvalid_o,
  input  wire logic        s_rready_i,
  // Pin side
  input  wire logic        pin_i,
  output logic             pin_digital_o,
  output logic [7:0]       func_route_o,
  output logic             high_drive_select_o,
  output logic             input_filter_on_o,
  output logic             irq_o
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    pcf_pkg::pcf_cfg_t cfg;
    logic              pin_event_flag;
    logic              irq_mask;
    logic              pin_prev;
    logic              aw_held;
    logic [3:0]        aw_addr;
    logic              w_held;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              b_pend;
    logic [1:0]        b_resp;
    logic              r_pend;
    pcf_pkg::pcf_rd_t  rd;
  } pcf_state_t;

  pcf_state_t state_r;
  pcf_state_t state_nxt;

  logic pin_sync;

  pcf_sync u_sync (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .clk_en_i  (clk_en_i),
    .async_i   (pin_i),
    .sync_o    (pin_sync)
  );

  // ****************************************
  // Trigger detection
  // ****************************************
  logic detect;

  always_comb begin
    detect = 1'b0;
    unique case (state_r.cfg.irq_trigger_select)
      pcf_pkg::TRIG_LOW:    detect = !pin_sync;
      pcf_pkg::TRIG_RISE:   detect = pin_sync && !state_r.pin_prev;
      pcf_pkg::TRIG_FALL:   detect = !pin_sync && state_r.pin_prev;
      pcf_pkg::TRIG_EITHER: detect = pin_sync != state_r.pin_prev;
      pcf_pkg::TRIG_HIGH:   detect = pin_sync;
      default:              detect = 1'b0;
    endcase
    if (!HAS_IRQ) begin
      detect = 1'b0;
    end
  end

  // ****************************************
  // Register read image
  // ****************************************
  function automatic logic [31:0] ctrl_image(pcf_state_t s);
    logic [31:0] v;
    v = pcf_pkg::READ_ZERO;
    v[pcf_pkg::FLAG_BIT]                   = s.pin_event_flag;
    v[pcf_pkg::TRIG_LSB +: 4]              = s.cfg.irq_trigger_select;
    v[pcf_pkg::FUNC_LSB +: 3]              = s.cfg.func_select;
    v[pcf_pkg::DRIVE_BIT]                  = s.cfg.high_drive_select;
    v[pcf_pkg::FILTER_BIT]                 = s.cfg.input_filter_on;
    return v;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  logic        wr_go;
  logic        rd_go;
  logic        clr_flag;
  logic [31:0] wmask;
  logic [31:0] wval;

  always_comb begin
    state_nxt = state_r;
    clr_flag  = 1'b0;
    wmask     = {{8{state_r.w_strb[3]}}, {8{state_r.w_strb[2]}},
                 {8{state_r.w_strb[1]}}, {8{state_r.w_strb[0]}}};
    wval      = state_r.w_data & wmask;
    wr_go     = state_r.aw_held && state_r.w_held && !state_r.b_pend;
    rd_go     = s_arvalid_i && !state_r.r_pend;

    state_nxt.pin_prev = pin_sync;

    // Address and data taken in either order
    if (s_awvalid_i && !state_r.aw_held) begin
      state_nxt.aw_held = 1'b1;
      state_nxt.aw_addr = s_awaddr_i;
    end
    if (s_wvalid_i && !state_r.w_held) begin
      state_nxt.w_held = 1'b1;
      state_nxt.w_data = s_wdata_i;
      state_nxt.w_strb = s_wstrb_i;
    end

    if (wr_go) begin
      state_nxt.aw_held = 1'b0;
      state_nxt.w_held  = 1'b0;
      state_nxt.b_pend  = 1'b1;
      state_nxt.b_resp  = pcf_pkg::RESP_OKAY;
      unique case (state_r.aw_addr)
        pcf_pkg::PIN_CONTROL_OFS: begin
          if (wmask[pcf_pkg::TRIG_LSB] && HAS_IRQ) begin
            state_nxt.cfg.irq_trigger_select = wval[pcf_pkg::TRIG_LSB +: 4];
          end
          if (wmask[pcf_pkg::FUNC_LSB]) begin
            state_nxt.cfg.func_select = wval[pcf_pkg::FUNC_LSB +: 3];
          end
          if (wmask[pcf_pkg::DRIVE_BIT] && HAS_DRIVE) begin
            state_nxt.cfg.high_drive_select = wval[pcf_pkg::DRIVE_BIT];
          end
          if (wmask[pcf_pkg::FILTER_BIT] && HAS_FILTER) begin
            state_nxt.cfg.input_filter_on = wval[pcf_pkg::FILTER_BIT];
          end
          clr_flag = wval[pcf_pkg::FLAG_BIT];
        end
        pcf_pkg::IRQ_STATUS_OFS: begin
          clr_flag = wval[0];
        end
        pcf_pkg::IRQ_MASK_OFS: begin
          if (wmask[0]) begin
            state_nxt.irq_mask = wval[0];
          end
        end
        pcf_pkg::PIN_STATUS_OFS: begin
          state_nxt.b_resp = pcf_pkg::RESP_OKAY;
        end
        default: begin
          state_nxt.b_resp = pcf_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (state_r.b_pend && s_bready_i) begin
      state_nxt.b_pend = 1'b0;
    end

    // Flag: detection wins over a clear in the same cycle
    if (clr_flag) begin
      state_nxt.pin_event_flag = 1'b0;
    end
    if (detect) begin
      state_nxt.pin_event_flag = 1'b1;
    end

    if (rd_go) begin
      state_nxt.r_pend  = 1'b1;
      state_nxt.rd.resp = pcf_pkg::RESP_OKAY;
      unique case (s_araddr_i)
        pcf_pkg::PIN_CONTROL_OFS: state_nxt.rd.data = ctrl_image(state_r);
        pcf_pkg::IRQ_STATUS_OFS:
          state_nxt.rd.data = {31'h0000_0000, state_r.pin_event_flag};
        pcf_pkg::IRQ_MASK_OFS:
          state_nxt.rd.data = {31'h0000_0000, state_r.irq_mask};
        pcf_pkg::PIN_STATUS_OFS:
          state_nxt.rd.data = {31'h0000_0000, pin_sync};
        default: begin
          state_nxt.rd.data = pcf_pkg::READ_ZERO;
          state_nxt.rd.resp = pcf_pkg::RESP_SLVERR;
        end
      endcase
    end else if (state_r.r_pend && s_rready_i) begin
      state_nxt.r_pend = 1'b0;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r                          <= '0;
      state_r.cfg.irq_trigger_select   <= pcf_pkg::TRIG_RESET;
      state_r.cfg.func_select          <= pcf_pkg::FUNC_RESET;
      state_r.cfg.high_drive_select    <= pcf_pkg::DRIVE_RESET;
      state_r.cfg.input_filter_on      <= pcf_pkg::FILTER_RESET;
      state_r.irq_mask                 <= pcf_pkg::MASK_RESET;
    end else if (clk_en_i) begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign s_awready_o = !state_r.aw_held;
  assign s_wready_o  = !state_r.w_held;
  assign s_bvalid_o  = state_r.b_pend;
  assign s_bresp_o   = state_r.b_resp;
  assign s_arready_o = !state_r.r_pend;
  assign s_rvalid_o  = state_r.r_pend;
  assign s_rdata_o   = state_r.rd.data;
  assign s_rresp_o   = state_r.rd.resp;

  // Routing and pad controls, valid in any digital slot
  always_comb begin
    func_route_o = 8'h00;
    func_route_o[state_r.cfg.func_select] = 1'b1;
  end
  assign pin_digital_o       = state_r.cfg.func_select != pcf_pkg::FUNC_ANALOG;
  assign high_drive_select_o = state_r.cfg.high_drive_select;
  assign input_filter_on_o   = state_r.cfg.input_filter_on;
  assign irq_o               = state_r.pin_event_flag && state_r.irq_mask;

endmodule

//--- dv/pcf_pin_model.sv
/*
  Pin-side model: drives the pin level, skewed against the bus clock.
  Assumes the bench sets the wanted level.
*/
module pcf_pin_model (
  input  wire logic level_i,
  output logic      pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin_o = 1'b0;
  // Lands away from the clock edges
  always @(level_i) pin_o <= #13 level_i;
endmodule

//--- dv/pcf_pin_control_asserts.sv
/*
  Checker for the pin control block: bus handshakes, routing, sticky flag.
  Assumes binding to pcf_pin_control in one clock domain.
*/
module pcf_pin_control_asserts (
  input wire logic        ref_clk_i,
  input wire logic        reset_n_i,
  input wire logic        s_awvalid_i,
  input wire logic        s_awready_o,
  input wire logic        s_wvalid_i,
  input wire logic        s_wready_o,
  input wire logic        s_bvalid_o,
  input wire logic        s_bready_i,
  input wire logic [3:0]  s_araddr_i,
  input wire logic        s_arvalid_i,
  input wire logic        s_arready_o,
  input wire logic [31:0] s_rdata_o,
  input wire logic        s_rvalid_o,
  input wire logic        s_rready_i,
  input wire logic [7:0]  func_route_o,
  input wire logic        pin_digital_o,
  input wire logic        high_drive_select_o,
  input wire logic        input_filter_on_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [3:0] rd_addr_r;
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      rd_addr_r <= 4'h0;
    else if (s_arvalid_i && s_arready_o)
      rd_addr_r <= s_araddr_i;
  end
  sequence rd_taken_s;
    s_arvalid_i && s_arready_o;
  endsequence
  sequence wr_taken_s;
    s_awvalid_i && s_awready_o && s_wvalid_i && s_wready_o;
  endsequence
  // ****************************************
  // Properties
  // ****************************************
  route_onehot_a: assert property ($onehot(func_route_o) && pin_digital_o == !func_route_o[0])
    else $error("route not one-hot");
  cfg_by_write_a: assert property (
    $changed({func_route_o, high_drive_select_o, input_filter_on_o}) |-> $rose(s_bvalid_o))
    else $error("config moved without write");
  irq_sticky_a: assert property ($fell(irq_o) |-> $rose(s_bvalid_o))
    else $error("irq dropped without write");
  bvalid_hold_a: assert property (s_bvalid_o && !s_bready_i |=> s_bvalid_o)
    else $error("bvalid dropped early");
  rvalid_hold_a: assert property (s_rvalid_o && !s_rready_i |=> s_rvalid_o && $stable(s_rdata_o))
    else $error("read data not held");
  ar_block_a: assert property (s_rvalid_o |-> !s_arready_o)
    else $error("arready while rvalid");
  read_answer_a: assert property (rd_taken_s |=> s_rvalid_o)
    else $error("read answer late");
  write_answer_a: assert property (wr_taken_s |-> ##[1:2] s_bvalid_o)
    else $error("write answer late");
  reserved_zero_a: assert property (
    s_rvalid_o && rd_addr_r == pcf_pkg::PIN_CONTROL_OFS |-> (s_rdata_o & 32'hFEF0_F8A8) == 0)
    else $error("reserved bit set");
endmodule
bind pcf_pin_control pcf_pin_control_asserts chk (.*);

//--- dv/pin_control_field_logic_bench.sv
/*
  Self-checking bench for the pin control block.
  Assumes the pin model and the bound checker are compiled alongside.
*/
module pin_control_field_logic_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0;
  logic arv = 1'b0, rready = 1'b0, lvl = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] route;
  logic awready, wready, bvalid, arready, rvalid, pin, pin_dig, drive, filter, irq;
  int n_errors = 0, compares = 0;
  pcf_pkg::pcf_rd_t exp_q[$];
  localparam logic [1:0] OK = pcf_pkg::RESP_OKAY;
  localparam logic [3:0] CTL = pcf_pkg::PIN_CONTROL_OFS, STS = pcf_pkg::IRQ_STATUS_OFS;
  pcf_pin_model pm (.level_i(lvl), .pin_o(pin));
  pcf_pin_control dut (
    .ref_clk_i(clk), .reset_n_i(rst_n), .clk_en_i(1'b1),
    .s_awaddr_i(awaddr), .s_awvalid_i(awv), .s_awready_o(awready),
    .s_wdata_i(wdata), .s_wstrb_i(4'hF), .s_wvalid_i(wv), .s_wready_o(wready),
    .s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready),
    .s_araddr_i(araddr), .s_arvalid_i(arv), .s_arready_o(arready),
    .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid), .s_rready_i(rready),
    .pin_i(pin), .pin_digital_o(pin_dig), .func_route_o(route),
    .high_drive_select_o(drive), .input_filter_on_o(filter), .irq_o(irq));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic report_and_stop();
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One bus transfer; expectation queued for the monitor
  task automatic xfer(input bit rd, input logic [3:0] a, input logic [31:0] d,
                      input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    exp_q.push_back({ed, er});
    @(posedge clk);
    araddr <= a;
    arv    <= rd;
    rready <= rd;
    awaddr <= a;
    wdata  <= d;
    awv    <= !rd;
    wv     <= !rd;
    bready <= !rd;
    do @(posedge clk); while (!(rd ? arready : awready && wready) && ++n < 50);
    arv <= 1'b0;
    awv <= 1'b0;
    wv  <= 1'b0;
    do @(posedge clk); while (!(rd ? rvalid : bvalid) && ++n < 50);
    rready <= 1'b0;
    bready <= 1'b0;
    if (n >= 50) begin
      n_errors++;
      report_and_stop();
    end
  endtask
  always @(posedge clk) begin
    if (rvalid && rready)
      chk({rdata, rresp}, exp_q.pop_front());
    else if (bvalid && bready)
      chk({32'h0, bresp}, exp_q.pop_front());
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    logic [31:0] d;
    logic [3:0] c;
    logic [3:0] codes [8] = '{4'hB, 4'hC, 4'h8, 4'h9, 4'hA, 4'h4, 4'hD, 4'h0};
    void'($urandom(32'h58EF));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    xfer(1, CTL, 0, 0, OK);
    xfer(1, STS, 0, 0, OK);
    chk({route, pin_dig, irq}, 10'h004);
    for (int i = 0; i < 8; i++) begin
      d = ($urandom() & 32'hFEF0_F8FF) | (i << 8);
      xfer(0, CTL, d, 0, OK);
      xfer(1, CTL, 0, d & 32'h0000_0750, OK);
      chk(route, 8'h01 << i);
      chk({pin_dig, drive, filter}, {i != 0, d[6], d[4]});
    end
    xfer(0, pcf_pkg::IRQ_MASK_OFS, 1, 0, OK);
    foreach (codes[j]) begin
      c = codes[j];
      xfer(0, CTL, {12'h0, c, 16'h0}, 0, OK);
      xfer(0, STS, 1, 0, OK);
      repeat (6) @(posedge clk);
      xfer(1, STS, 0, c == 4'h8, OK);
      lvl <= 1'b1;
      repeat (6) @(posedge clk);
      xfer(1, STS, 0, c inside {4'h8, 4'h9, 4'hB, 4'hC}, OK);
      xfer(0, STS, 1, 0, OK);
      xfer(1, STS, 0, c == 4'hC, OK);
      lvl <= 1'b0;
      repeat (6) @(posedge clk);
      xfer(1, STS, 0, c inside {4'h8, 4'hA, 4'hB, 4'hC}, OK);
      chk(irq, c inside {4'h8, 4'hA, 4'hB, 4'hC});
    end
    xfer(0, CTL, 32'h0008_0000, 0, OK);
    xfer(0, pcf_pkg::IRQ_MASK_OFS, 0, 0, OK);
    chk(irq, 1'b0);
    xfer(0, CTL, 32'h0100_0000, 0, OK);
    xfer(1, STS, 0, 1, OK);
    xfer(0, CTL, 32'h0100_0000, 0, OK);
    xfer(1, STS, 0, 0, OK);
    xfer(1, pcf_pkg::PIN_STATUS_OFS, 0, 0, OK);
    xfer(0, 4'h2, 32'hFFFF_FFFF, 0, pcf_pkg::RESP_SLVERR);
    xfer(1, 4'h2, 0, 0, pcf_pkg::RESP_SLVERR);
    report_and_stop();
  end
endmodule
